/* File: logic/pcs_coding_path.sv */
module pcs_coding_path
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // transmit nibbles from the MAC
  input wire logic [3:0] mac_tx_nibble,
  input wire logic mac_tx_nibble_valid,
  output logic mac_tx_ready,
  // transmit line streams
  output logic line_tx_pos,
  output logic line_tx_neg,
  output logic line_tx_nrzi,
  // receive line levels
  input wire logic line_rx_pos,
  input wire logic line_rx_neg,
  // receive nibbles to the MAC
  output logic [3:0] mac_rx_nibble,
  output logic mac_rx_nibble_strobe,
  output logic mac_rx_frame,
  output logic mac_rx_error,
  output logic rx_scr_locked
);

  typedef struct packed {
    // transmit
    tx_state_t tx_state;
    logic tx_ready;
    // serializer, scrambler and line coding
    logic [4:0] ser_sh;
    logic [2:0] ser_cnt;
    logic [10:0] tx_lfsr;
    logic tx_nrzi;
    logic [1:0] mlt_phase;
    logic tx_pos;
    logic tx_neg;
    // receive
    // line retiming
    logic [1:0] rx_lvl;
    logic rx_nrzi;
    logic rx_nrzi_d;
    logic [4:0] rx_raw;
    // descrambler and its lock
    logic [10:0] rx_lfsr;
    logic rx_locked;
    logic [5:0] sync_cnt;
    // alignment and decoder
    logic [9:0] rx_win;
    rx_state_t rx_state;
    logic [2:0] grp_cnt;
    logic pre_pend;
    logic [3:0] rx_nib;
    logic rx_strobe;
    logic rx_frame;
    logic rx_err;
  } pcs_st_t;

  localparam pcs_st_t ST_RESET = '{
    tx_state: TX_IDLE,
    tx_ready: 1'b0,
    ser_sh: CG_IDLE,
    ser_cnt: GRP_LAST,
    tx_lfsr: SCR_SEED,
    tx_nrzi: 1'b0,
    mlt_phase: 2'h0,
    tx_pos: 1'b0,
    tx_neg: 1'b0,
    rx_lvl: 2'h0,
    rx_nrzi: 1'b0,
    rx_nrzi_d: 1'b0,
    rx_raw: 5'h00,
    rx_lfsr: SCR_SEED,
    rx_locked: 1'b0,
    sync_cnt: 6'h00,
    rx_win: 10'h000,
    rx_state: RX_HUNT,
    grp_cnt: 3'h0,
    pre_pend: 1'b0,
    rx_nib: 4'h0,
    rx_strobe: 1'b0,
    rx_frame: 1'b0,
    rx_err: 1'b0
  };

  pcs_st_t s_reg;
  pcs_st_t s_next;

  // code group fifo between encoder and serializer
  // fill side feeds its own ready back: idle pads every free slot
  logic push_ready;
  logic [4:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [4:0] pop_data;
  logic [FIFO_LVL_W-1:0] fifo_level;

  data_fifo #(
    .WIDTH(CG_W),
    .DEPTH(FIFO_DEPTH),
    .LVL_W(FIFO_LVL_W),
    .PTR_W(FIFO_PTR_W)
  ) u_cg_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_ready),
    .in_data(push_data),
    .in_ready(push_ready),
    .out_valid(pop_valid),
    .out_data(pop_data),
    .out_ready(pop_ready),
    .level(fifo_level)
  );

  // next group is taken as the last bit of the current one leaves
  assign pop_ready = s_reg.ser_cnt == 3'h0;

  // one next-state process for both directions

  always_comb begin
    logic take;
    logic tx_bit;
    logic scr_bit;
    logic [FIFO_LVL_W-1:0] lvl_next;
    logic [1:0] lvl_in;
    logic nrz_bit;
    logic dbit;
    logic [9:0] win_next;
    logic [4:0] grp;
    logic [4:0] dec;
    logic grp_due;
    take = 1'b0;
    tx_bit = 1'b0;
    scr_bit = 1'b0;
    lvl_next = '0;
    lvl_in = 2'h0;
    nrz_bit = 1'b0;
    dbit = 1'b0;
    win_next = '0;
    grp = '0;
    dec = '0;
    grp_due = 1'b0;
    s_next = s_reg;
    push_data = CG_IDLE;

    // encoder: a push happens in every cycle the fifo has room
    take = s_reg.tx_ready && mac_tx_nibble_valid;
    case (s_reg.tx_state)
      TX_IDLE: begin
        if (take) begin
          push_data = CG_J;
          s_next.tx_state = TX_K;
        end else begin
          push_data = CG_IDLE;
        end
      end
      TX_K: begin
        // valid low right after J: the frame closes as J, T, R
        if (take) begin
          push_data = CG_K;
          s_next.tx_state = TX_DATA;
        end else if (push_ready) begin
          push_data = CG_T;
          s_next.tx_state = TX_R;
        end
      end
      TX_DATA: begin
        if (take) begin
          push_data = enc_nibble(mac_tx_nibble);
        end else if (push_ready) begin
          push_data = CG_T;
          s_next.tx_state = TX_R;
        end
      end
      TX_R: begin
        push_data = CG_R;
        if (push_ready) begin
          s_next.tx_state = TX_IDLE;
        end
      end
      default: begin
        s_next.tx_state = TX_IDLE;
      end
    endcase

    // ready next cycle: accepting state and room after this cycle
    // ready is a flop, so it looks one cycle ahead at the fill level
    lvl_next = fifo_level;
    if (push_ready) begin
      lvl_next = lvl_next + 1'b1;
    end
    if (pop_ready && pop_valid) begin
      lvl_next = lvl_next - 1'b1;
    end
    s_next.tx_ready = (lvl_next != FIFO_LVL_W'(FIFO_DEPTH)) &&
      (s_next.tx_state != TX_R);

    // serializer, scrambler, NRZI and MLT-3 split
    tx_bit = s_reg.ser_sh[4];
    if (s_reg.ser_cnt == 3'h0) begin
      // empty fifo sends idle rather than stalling the line
      s_next.ser_sh = pop_valid ? pop_data : CG_IDLE;
      s_next.ser_cnt = GRP_LAST;
    end else begin
      s_next.ser_sh = {s_reg.ser_sh[3:0], 1'b0};
      s_next.ser_cnt = s_reg.ser_cnt - 1'b1;
    end
    scr_bit = tx_bit ^ scr_key(s_reg.tx_lfsr);
    s_next.tx_lfsr = {s_reg.tx_lfsr[9:0], scr_key(s_reg.tx_lfsr)};
    s_next.tx_nrzi = s_reg.tx_nrzi ^ scr_bit;
    if (scr_bit) begin
      s_next.mlt_phase = s_reg.mlt_phase + 1'b1;
    end
    // phase 1 drives the positive side, phase 3 the negative
    s_next.tx_pos = s_next.mlt_phase == 2'h1;
    s_next.tx_neg = s_next.mlt_phase == 2'h3;

    // receive: retime, MLT-3 to NRZI, NRZI to NRZ
    lvl_in = {line_rx_pos, line_rx_neg};
    s_next.rx_lvl = lvl_in;
    // any level change between two samples is an NRZI transition
    s_next.rx_nrzi = s_reg.rx_nrzi ^ (lvl_in != s_reg.rx_lvl);
    s_next.rx_nrzi_d = s_reg.rx_nrzi;
    nrz_bit = s_reg.rx_nrzi ^ s_reg.rx_nrzi_d;
    s_next.rx_raw = {s_reg.rx_raw[3:0], nrz_bit};

    // descrambler and its sync on idle
    // idle is all ones, so an inverted line bit is a key bit
    // a failed check before lock reloads the key from the stream
    dbit = s_reg.rx_raw[0] ^ scr_key(s_reg.rx_lfsr);
    if (s_reg.sync_cnt < SYNC_LOAD_BITS) begin
      s_next.rx_lfsr = {s_reg.rx_lfsr[9:0], ~s_reg.rx_raw[0]};
      s_next.sync_cnt = s_reg.sync_cnt + 1'b1;
    end else begin
      s_next.rx_lfsr = {s_reg.rx_lfsr[9:0], scr_key(s_reg.rx_lfsr)};
      if (!s_reg.rx_locked) begin
        if (!dbit) begin
          s_next.sync_cnt = 6'h00;
        end else if (s_reg.sync_cnt == SYNC_DONE_BITS) begin
          s_next.rx_locked = 1'b1;
        end else begin
          s_next.sync_cnt = s_reg.sync_cnt + 1'b1;
        end
      end
    end
    win_next = {s_reg.rx_win[8:0], dbit};
    s_next.rx_win = win_next;

    // alignment and decode
    // boundary counter restarts on J/K so groups stay aligned to it
    // preamble pair: one nibble at detection, the second one after
    s_next.rx_strobe = 1'b0;
    s_next.rx_err = 1'b0;
    s_next.pre_pend = 1'b0;
    if (s_reg.pre_pend) begin
      s_next.rx_nib = NIB_PREAMBLE;
      s_next.rx_strobe = 1'b1;
    end
    grp_due = s_reg.grp_cnt == GRP_LAST;
    s_next.grp_cnt = grp_due ? 3'h0 : s_reg.grp_cnt + 1'b1;
    grp = win_next[4:0];
    dec = dec_group(grp);
    case (s_reg.rx_state)
      RX_HUNT: begin
        if (s_reg.rx_locked && win_next == {CG_J, CG_K}) begin
          s_next.rx_state = RX_FRAME;
          s_next.grp_cnt = 3'h0;
          s_next.rx_frame = 1'b1;
          s_next.rx_nib = NIB_PREAMBLE;
          s_next.rx_strobe = 1'b1;
          s_next.pre_pend = 1'b1;
        end
      end
      RX_FRAME: begin
        if (grp_due) begin
          if (grp == CG_T) begin
            s_next.rx_state = RX_END;
            s_next.rx_frame = 1'b0;
          end else if (grp == CG_IDLE) begin
            // idle inside a frame: the frame was cut, flag and hunt
            s_next.rx_state = RX_HUNT;
            s_next.rx_frame = 1'b0;
            s_next.rx_err = 1'b1;
          end else begin
            s_next.rx_nib = dec[3:0];
            s_next.rx_strobe = 1'b1;
            s_next.rx_err = ~dec[4];
          end
        end
      end
      RX_END: begin
        // anything but R after T is flagged
        if (grp_due) begin
          s_next.rx_state = RX_HUNT;
          s_next.rx_err = grp != CG_R;
        end
      end
      default: begin
        s_next.rx_state = RX_HUNT;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= ST_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state flops
  assign mac_tx_ready = s_reg.tx_ready;
  assign line_tx_pos = s_reg.tx_pos;
  assign line_tx_neg = s_reg.tx_neg;
  assign line_tx_nrzi = s_reg.tx_nrzi;
  assign mac_rx_nibble = s_reg.rx_nib;
  assign mac_rx_nibble_strobe = s_reg.rx_strobe;
  assign mac_rx_frame = s_reg.rx_frame;
  assign mac_rx_error = s_reg.rx_err;
  assign rx_scr_locked = s_reg.rx_locked;

endmodule

/* File: logic/pcs_pkg.sv */
package pcs_pkg;

  // clock and word sizes
  localparam int CLK_PERIOD_NS = 100;
  localparam int NIB_W = 4;
  localparam int CG_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_LVL_W = 5;
  localparam int FIFO_PTR_W = 4;

  // code groups with a special meaning
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;

  // scrambler: x^11 + x^9 + 1
  localparam int SCR_W = 11;
  localparam int SCR_TAP_HI = 10;
  localparam int SCR_TAP_LO = 8;
  localparam logic [10:0] SCR_SEED = 11'h7FF;

  // descrambler lock: bits loaded, then idle bits checked
  localparam logic [5:0] SYNC_LOAD_BITS = 6'h0B;
  localparam logic [5:0] SYNC_DONE_BITS = 6'h1F;

  // group boundary counter
  localparam logic [2:0] GRP_LAST = 3'h4;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_K    = 4'b0010,
    TX_DATA = 4'b0100,
    TX_R    = 4'b1000
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_HUNT  = 3'b001,
    RX_FRAME = 3'b010,
    RX_END   = 3'b100
  } rx_state_t;

  function automatic logic scr_key(input logic [10:0] s);
    return s[SCR_TAP_HI] ^ s[SCR_TAP_LO];
  endfunction

  function automatic logic [4:0] enc_nibble(input logic [3:0] n);
    case (n)
      4'h0: return 5'h1E;
      4'h1: return 5'h09;
      4'h2: return 5'h14;
      4'h3: return 5'h15;
      4'h4: return 5'h0A;
      4'h5: return 5'h0B;
      4'h6: return 5'h0E;
      4'h7: return 5'h0F;
      4'h8: return 5'h12;
      4'h9: return 5'h13;
      4'hA: return 5'h16;
      4'hB: return 5'h17;
      4'hC: return 5'h1A;
      4'hD: return 5'h1B;
      4'hE: return 5'h1C;
      default: return 5'h1D;
    endcase
  endfunction

  // returns {valid, nibble}
  function automatic logic [4:0] dec_group(input logic [4:0] g);
    case (g)
      5'h1E: return 5'h10;
      5'h09: return 5'h11;
      5'h14: return 5'h12;
      5'h15: return 5'h13;
      5'h0A: return 5'h14;
      5'h0B: return 5'h15;
      5'h0E: return 5'h16;
      5'h0F: return 5'h17;
      5'h12: return 5'h18;
      5'h13: return 5'h19;
      5'h16: return 5'h1A;
      5'h17: return 5'h1B;
      5'h1A: return 5'h1C;
      5'h1B: return 5'h1D;
      5'h1C: return 5'h1E;
      5'h1D: return 5'h1F;
      default: return 5'h00;
    endcase
  endfunction

endpackage

/* File: logic/data_fifo.sv */
module data_fifo
  import pcs_pkg::*;
#(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16,
  parameter int LVL_W = 5,
  parameter int PTR_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // fill level
  output logic [LVL_W-1:0] level
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [LVL_W-1:0] cnt;
  } fifo_st_t;

  fifo_st_t s_reg;
  fifo_st_t s_next;
  logic wr_en;
  logic rd_en;

  assign in_ready = s_reg.cnt != LVL_W'(DEPTH);
  assign out_valid = s_reg.cnt != '0;
  assign out_data = s_reg.mem[s_reg.rd];
  assign level = s_reg.cnt;

  always_comb begin
    s_next = s_reg;
    wr_en = in_valid && in_ready;
    rd_en = out_valid && out_ready;
    if (wr_en) begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = s_reg.wr + 1'b1;
    end
    if (rd_en) begin
      s_next.rd = s_reg.rd + 1'b1;
    end
    if (wr_en && !rd_en) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end else if (rd_en && !wr_en) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

/* File: tb/pcs_coding_path_asserts.sv */
module pcs_coding_path_chk
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // transmit side
  input wire logic mac_tx_nibble_valid,
  input wire logic mac_tx_ready,
  input wire logic line_tx_pos,
  input wire logic line_tx_neg,
  // receive side
  input wire logic [3:0] mac_rx_nibble,
  input wire logic mac_rx_nibble_strobe,
  input wire logic mac_rx_frame,
  input wire logic rx_scr_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  logic neg_last_reg;
  logic in_frame_reg;

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  // last nonzero level, and open transmit frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      neg_last_reg <= 1'b1;
      in_frame_reg <= 1'b0;
    end else begin
      if (line_tx_pos || line_tx_neg) begin
        neg_last_reg <= line_tx_neg;
      end
      if (mac_tx_ready) begin
        in_frame_reg <= mac_tx_nibble_valid;
      end
    end
  end

  property p_mlt_excl;
    !(line_tx_pos && line_tx_neg);
  endproperty
  a_mlt_excl: assert property (p_mlt_excl)
    else $error("both line streams high");

  property p_mlt_zero;
    line_tx_pos |=> !line_tx_neg;
  endproperty
  a_mlt_zero: assert property (p_mlt_zero)
    else $error("no zero level between phases");

  property p_mlt_alt;
    $rose(line_tx_pos) |-> neg_last_reg;
  endproperty
  a_mlt_alt: assert property (p_mlt_alt)
    else $error("positive events not alternating");

  property p_tx_end;
    in_frame_reg && mac_tx_ready && !mac_tx_nibble_valid |=> !mac_tx_ready;
  endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("ready stayed high at frame end");

  property p_lock_hold;
    rx_scr_locked |=> rx_scr_locked;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("lock lost");

  property p_jk_locked;
    $rose(mac_rx_frame) |-> rx_scr_locked;
  endproperty
  a_jk_locked: assert property (p_jk_locked)
    else $error("frame opened while unlocked");

  property p_pre_pair;
    $rose(mac_rx_frame) |-> (mac_rx_nibble_strobe
      && mac_rx_nibble == NIB_PREAMBLE) ##1 (mac_rx_nibble_strobe
      && mac_rx_nibble == NIB_PREAMBLE) ##1 !mac_rx_nibble_strobe [*3]
      ##1 (mac_rx_nibble_strobe || !mac_rx_frame);
  endproperty
  a_pre_pair: assert property (p_pre_pair)
    else $error("bad preamble pair after delimiter");

  property p_strobe_in;
    mac_rx_nibble_strobe |-> mac_rx_frame;
  endproperty
  a_strobe_in: assert property (p_strobe_in)
    else $error("nibble delivered outside frame");
endmodule

bind pcs_coding_path pcs_coding_path_chk u_pcs_coding_path_chk (
  .clk(clk), .rst(rst), .mac_tx_nibble_valid(mac_tx_nibble_valid),
  .mac_tx_ready(mac_tx_ready), .line_tx_pos(line_tx_pos),
  .line_tx_neg(line_tx_neg), .mac_rx_nibble(mac_rx_nibble),
  .mac_rx_nibble_strobe(mac_rx_nibble_strobe),
  .mac_rx_frame(mac_rx_frame), .rx_scr_locked(rx_scr_locked)
);

/* File: tb/line_partner.sv */
module line_partner #(
  parameter int DELAY = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // streams from the far transmitter
  input wire logic tx_pos,
  input wire logic tx_neg,
  // fault injection: silences the line
  input wire logic mute,
  // levels toward the receiver
  output logic rx_pos,
  output logic rx_neg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DELAY-1:0] pos_reg;
  logic [DELAY-1:0] neg_reg;

  // cable delay, line silent during reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_reg <= '0;
      neg_reg <= '0;
    end else begin
      pos_reg <= (pos_reg << 1) | DELAY'(tx_pos && !mute);
      neg_reg <= (neg_reg << 1) | DELAY'(tx_neg && !mute);
    end
  end
  assign rx_pos = pos_reg[DELAY-1];
  assign rx_neg = neg_reg[DELAY-1];
endmodule

/* File: tb/tb_pcs_coding_path.sv */
module tb_pcs_coding_path
  import pcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A,
    5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C,
    5'h1D};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] mac_tx_nibble = 4'h0;
  logic mac_tx_nibble_valid = 1'b0;
  logic line_mute = 1'b0;
  logic mac_tx_ready, line_tx_pos, line_tx_neg, line_tx_nrzi;
  logic line_rx_pos, line_rx_neg, mac_rx_nibble_strobe;
  logic mac_rx_frame, mac_rx_error, rx_scr_locked, mprev;
  logic [3:0] mac_rx_nibble;
  logic [10:0] ms;
  logic [9:0] mw;
  logic [4:0] tq [$];
  logic [4:0] eg [$];
  logic [3:0] rq [$];
  logic [3:0] en [$];
  int errors = 0;
  int cmp_count = 0;
  int rcnt = 0;
  int ecnt = 0;
  int mcnt = 0;
  int mbit = 0;

  always #50 clk = ~clk;

  pcs_coding_path u_pcs_coding_path (
    .clk(clk), .rst(rst), .mac_tx_nibble(mac_tx_nibble),
    .mac_tx_nibble_valid(mac_tx_nibble_valid), .mac_tx_ready(mac_tx_ready),
    .line_tx_pos(line_tx_pos), .line_tx_neg(line_tx_neg),
    .line_tx_nrzi(line_tx_nrzi), .line_rx_pos(line_rx_pos),
    .line_rx_neg(line_rx_neg), .mac_rx_nibble(mac_rx_nibble),
    .mac_rx_nibble_strobe(mac_rx_nibble_strobe),
    .mac_rx_frame(mac_rx_frame), .mac_rx_error(mac_rx_error),
    .rx_scr_locked(rx_scr_locked)
  );

  line_partner #(.DELAY(3)) u_line_partner (
    .clk(clk), .rst(rst), .tx_pos(line_tx_pos), .tx_neg(line_tx_neg),
    .rx_pos(line_rx_pos), .rx_neg(line_rx_neg), .mute(line_mute)
  );

  // line decode: key loaded from idle, then groups after each delimiter
  always @(negedge clk) begin : tx_mon
    logic nz;
    logic d;
    nz = line_tx_nrzi ^ mprev;
    mprev = line_tx_nrzi;
    if (rst) begin
      mcnt = 0;
    end else if (mcnt < 61) begin
      mcnt++;
      ms = {ms[9:0], ~nz};
    end else begin
      d = ms[10] ^ ms[8];
      ms = {ms[9:0], d};
      mw = {mw[8:0], nz ^ d};
      if (mbit == 0 && mw == {CG_J, CG_K}) begin
        tq.push_back(CG_J);
        tq.push_back(CG_K);
        mbit = 5;
      end else if (mbit > 1) begin
        mbit--;
      end else if (mbit == 1) begin
        tq.push_back(mw[4:0]);
        mbit = (mw[4:0] == CG_R) ? 0 : 5;
        if (mbit == 0) rcnt++;
      end
    end
  end

  always @(negedge clk) begin
    if (mac_rx_nibble_strobe === 1'b1) rq.push_back(mac_rx_nibble);
    if (mac_rx_error === 1'b1) ecnt++;
  end

  task automatic bad(input string what);
    errors++;
    $display("unexpected at %0t: %s", $time, what);
  endtask

  task automatic chk_grp(input logic [4:0] got, input logic [4:0] exp);
    cmp_count++;
    if (got !== exp) bad($sformatf("group %b not %b", got, exp));
  endtask

  task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) bad($sformatf("nibble %h not %h", got, exp));
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) bad("flag wrong");
  endtask

  task automatic wait_ready();
    for (int k = 0; k < 100 && mac_tx_ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
  endtask

  task automatic send(input logic [3:0] n[$]);
    if (n.size() > 1) begin
      eg.push_back(CG_J);
      eg.push_back(CG_K);
      en.push_back(NIB_PREAMBLE);
      en.push_back(NIB_PREAMBLE);
      for (int i = 2; i < n.size(); i++) begin
        eg.push_back(ENC[n[i]]);
        en.push_back(n[i]);
      end
      eg.push_back(CG_T);
      eg.push_back(CG_R);
    end
    foreach (n[i]) begin
      mac_tx_nibble = n[i];
      mac_tx_nibble_valid = 1'b1;
      wait_ready();
    end
    mac_tx_nibble_valid = 1'b0;
    wait_ready();
  endtask

  task automatic drain(input int frames);
    for (int k = 0; k < 900; k++) begin
      if (rcnt >= frames && mac_rx_frame === 1'b0) break;
      @(negedge clk);
    end
    repeat (10) @(negedge clk);
    chk_bit(tq.size() == eg.size(), 1'b1);
    foreach (eg[i]) chk_grp(tq[i], eg[i]);
    chk_bit(rq.size() == en.size(), 1'b1);
    foreach (en[i]) chk_nib(rq[i], en[i]);
    chk_bit(ecnt == 0, 1'b1);
    chk_grp(mw[4:0], CG_IDLE);
    tq.delete();
    eg.delete();
    rq.delete();
    en.delete();
    rcnt = 0;
  endtask

  task automatic t_lock();
    for (int k = 0; k < 300 && rx_scr_locked !== 1'b1; k++) @(negedge clk);
    chk_bit(rx_scr_locked, 1'b1);
    chk_bit(mac_rx_frame, 1'b0);
    $display("test lock done");
  endtask

  task automatic t_codes();
    logic [3:0] n[$];
    n = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'hD};
    for (int i = 0; i < 16; i++) n.push_back(i[3:0]);
    send(n);
    drain(1);
    $display("test codes done");
  endtask

  task automatic t_back();
    send('{4'h5, 4'h5});
    send('{4'h9});
    send('{4'h5, 4'h5, 4'hA, 4'h3});
    drain(2);
    $display("test back to back done");
  endtask

  task automatic t_error();
    logic [3:0] n[$];
    n = '{4'h5, 4'h5};
    for (int i = 0; i < 24; i++) n.push_back(4'h7);
    send(n);
    for (int k = 0; k < 300 && mac_rx_frame !== 1'b1; k++) @(negedge clk);
    line_mute = 1'b1;
    repeat (60) @(negedge clk);
    line_mute = 1'b0;
    for (int k = 0; k < 400 && (rcnt < 1 || mac_rx_frame !== 1'b0); k++)
      @(negedge clk);
    repeat (20) @(negedge clk);
    chk_bit(ecnt != 0, 1'b1);
    chk_bit(mac_rx_frame, 1'b0);
    chk_bit(rx_scr_locked, 1'b1);
    $display("test line fault done");
  endtask

  task automatic stop_test();
    $display("compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    bad("watchdog");
    stop_test();
  end

  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_lock();
    t_codes();
    t_back();
    t_error();
    stop_test();
  end
endmodule
